/* gate_ctrl_pkg.sv */
// Constants shared by the full-bridge gate control block
package gate_ctrl_pkg;
  localparam int CLK_MHZ = 100;
  // Dead time with no timing resistor fitted
  localparam int DEAD_TIME_NS = 6000;
  localparam int DEAD_CYCLES = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
  // Fault blanking interval after a gate turns on
  localparam int BLANK_TIME_NS = 3000;
  localparam int BLANK_CYCLES = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
  // Longest reset low pulse that only clears faults
  localparam int RES_PULSE_US = 20;
  localparam int RES_PULSE_CYCLES = RES_PULSE_US * CLK_MHZ;
  // Capacitor discharge delay before sleep, and charge pump settling
  localparam int SLEEP_DELAY_US = 2000;
  localparam int SLEEP_DELAY_CYCLES = SLEEP_DELAY_US * CLK_MHZ;
  localparam int PUMP_SETTLE_US = 3000;
  localparam int PUMP_SETTLE_CYCLES = PUMP_SETTLE_US * CLK_MHZ;

  localparam int CNT_W = 20;
  localparam int TIME_W = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEAD = 8'h04;
  localparam logic [7:0] ADDR_BLANK = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_INT_STAT = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK = 8'h14;

  // Reset values
  localparam logic [TIME_W-1:0] DEAD_RESET = TIME_W'(DEAD_CYCLES);
  localparam logic [TIME_W-1:0] BLANK_RESET = TIME_W'(BLANK_CYCLES);
  localparam logic [3:0] INT_MASK_RESET = 4'h0;

  // Field positions
  localparam int CTRL_SW_DISABLE = 0;
  localparam int INT_SHORT = 0;
  localparam int INT_BOOT = 1;
  localparam int INT_SLEEP = 2;
  localparam int INT_WAKE = 3;

  typedef enum logic [1:0] {PIN_RUN, PIN_LOW, PIN_SLEEP, PIN_WAKE} pin_state_t;
endpackage : gate_ctrl_pkg

/* full_bridge_gate_control.sv */
// Full-bridge gate decode, dead time, short monitor and reset/sleep control
// Behaviour
// - Both chops high, direction high: leg A top and leg B bottom on.
// - Both chops high, direction low: leg B top and leg A bottom on.
// - Top chop low, bottom high, rectify on: both bottom gates on.
// - Top chop high, bottom low, rectify on: both top gates on.
// - Top low, bottom high, rectify off: one bottom gate chosen by direction.
// - Top high, bottom low, rectify off: one top gate chosen by direction.
// - Both chops low: all four gates off.
// - Reset pin held low disables everything and enters sleep after a delay.
// - Entering sleep clears all latched faults and faultOut; the interrupt status flags stay set.
// - Leaving sleep keeps gates off until the charge pump settles.
// - A short reset low pulse clears latched faults without sleeping.
// - Chops and rectify all low force every gate off.
// - Short comparison is only honoured after a blanking interval.
// - Threshold above disable level turns short detection off entirely.
// - Dead time separates one gate off from its complement on.
`timescale 1ns/1ns
`default_nettype none
module full_bridge_gate_control
  import gate_ctrl_pkg::*;
#(
  parameter int SLEEP_CYC = SLEEP_DELAY_CYCLES,
  parameter int PUMP_CYC = PUMP_SETTLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic highSideChopIn,
  input wire logic lowSideChopIn,
  input wire logic directionIn,
  input wire logic syncRectifyEnable,
  input wire logic resetPinN,
  input wire logic [3:0] shortCmpIn,
  input wire logic shortDisableIn,
  input wire logic bootstrapTimeoutIn,
  output logic gateTopLegA,
  output logic gateBottomLegA,
  output logic gateTopLegB,
  output logic gateBottomLegB,
  output logic sleepOut,
  output logic faultOut,
  output logic irqOut
);
  localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_CYC - 1);
  localparam logic [CNT_W-1:0] PUMP_LAST = CNT_W'(PUMP_CYC - 1);
  localparam logic [CNT_W-1:0] RES_LIMIT = CNT_W'(RES_PULSE_CYCLES);

  pin_state_t pinState_ff;
  logic [CNT_W-1:0] pinCnt_ff;
  logic [1:0] tgtHi, tgtLo;
  logic [1:0] gateHi_ff, gateLo_ff, nxt_gateHi, nxt_gateLo;
  logic [TIME_W-1:0] deadCnt_ff [2];
  logic [TIME_W-1:0] blankCnt_ff [4];
  logic [3:0] fetOn, shortHit;
  logic shortFault_ff, bootFault_ff, swDisable_ff;
  logic [TIME_W-1:0] deadTime_ff, blankTime_ff;
  logic [3:0] intStat_ff, intMask_ff, intEvt;
  logic gatesAllowed, faultClear, apbDone, apbRead;
  logic [31:0] rdMux;
  logic rdHit;

  // Reset pin: short pulse, sleep entry and charge pump settling
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinState_ff <= PIN_RUN;
      pinCnt_ff <= '0;
    end else begin
      case (pinState_ff)
        PIN_RUN: begin
          pinCnt_ff <= '0;
          if (!resetPinN) pinState_ff <= PIN_LOW;
        end
        PIN_LOW: begin
          pinCnt_ff <= pinCnt_ff + 1'b1;
          if (resetPinN) begin
            pinCnt_ff <= '0;
            // short pulse return
            // Pulses longer than the limit have begun discharging the pump
            pinState_ff <= (pinCnt_ff < RES_LIMIT) ? PIN_RUN : PIN_WAKE;
          end else if (pinCnt_ff >= SLEEP_LAST) begin
            pinState_ff <= PIN_SLEEP;
          end
        end
        PIN_SLEEP: begin
          pinCnt_ff <= '0;
          if (resetPinN) pinState_ff <= PIN_WAKE;
        end
        PIN_WAKE: begin
          pinCnt_ff <= pinCnt_ff + 1'b1;
          if (!resetPinN) begin
            pinCnt_ff <= '0;
            pinState_ff <= PIN_LOW;
          end else if (pinCnt_ff >= PUMP_LAST) begin
            pinState_ff <= PIN_RUN;
          end
        end
        default: pinState_ff <= PIN_RUN;
      endcase
    end
  end

  // Any reset pin low period wipes latched faults
  assign faultClear = (pinState_ff == PIN_LOW) || (pinState_ff == PIN_SLEEP);
  assign gatesAllowed = (pinState_ff == PIN_RUN) && resetPinN && !shortFault_ff
                        && !bootFault_ff;

  // Truth table decode; index 0 is leg A, 1 is leg B
  always_comb begin
    tgtHi = 2'h0;
    tgtLo = 2'h0;
    case ({highSideChopIn, lowSideChopIn})
      2'h3: begin
        tgtHi = directionIn ? 2'h1 : 2'h2;
        tgtLo = directionIn ? 2'h2 : 2'h1;
      end
      2'h1: tgtLo = syncRectifyEnable ? 2'h3 : (directionIn ? 2'h2 : 2'h1);
      2'h2: tgtHi = syncRectifyEnable ? 2'h3 : (directionIn ? 2'h1 : 2'h2);
      default: begin
        tgtHi = 2'h0;
        tgtLo = 2'h0;
      end
    endcase
  end

  // Per leg gate sequencing
  genvar leg;
  generate
    for (leg = 0; leg < 2; leg++) begin : g_leg
      logic wantHi, wantLo, quiet;
      assign wantHi = tgtHi[leg] && gatesAllowed;
      assign wantLo = tgtLo[leg] && gatesAllowed;
      assign quiet = (deadCnt_ff[leg] == '0);
      // guarded turn-on
      // Turn-off is immediate; turn-on waits for complement off plus dead time
      assign nxt_gateHi[leg] = wantHi && (gateHi_ff[leg] || (!gateLo_ff[leg] && quiet));
      assign nxt_gateLo[leg] = wantLo && !nxt_gateHi[leg]
                               && (gateLo_ff[leg] || (!gateHi_ff[leg] && quiet));
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          gateHi_ff[leg] <= 1'b0;
          gateLo_ff[leg] <= 1'b0;
          deadCnt_ff[leg] <= '0;
        end else begin
          gateHi_ff[leg] <= nxt_gateHi[leg];
          gateLo_ff[leg] <= nxt_gateLo[leg];
          if ((gateHi_ff[leg] && !nxt_gateHi[leg]) || (gateLo_ff[leg] && !nxt_gateLo[leg]))
            deadCnt_ff[leg] <= deadTime_ff;
          else if (!quiet)
            deadCnt_ff[leg] <= deadCnt_ff[leg] - 1'b1;
        end
      end
    end
  endgenerate

  assign fetOn = {gateLo_ff[1], gateHi_ff[1], gateLo_ff[0], gateHi_ff[0]};

  // Per transistor short monitor
  // Counters reload while a transistor is off, so every turn-on is blanked afresh
  genvar fet;
  generate
    for (fet = 0; fet < 4; fet++) begin : g_fet
      always_ff @(posedge sys_clk) begin
        if (sys_rst)
          blankCnt_ff[fet] <= '0;
        else if (!fetOn[fet])
          blankCnt_ff[fet] <= blankTime_ff;
        else if (blankCnt_ff[fet] != '0)
          blankCnt_ff[fet] <= blankCnt_ff[fet] - 1'b1;
      end
      assign shortHit[fet] = fetOn[fet] && (blankCnt_ff[fet] == '0) && shortCmpIn[fet]
                             && !shortDisableIn && !swDisable_ff;
    end
  endgenerate

  // A latched fault holds every gate off until the reset pin is pulsed low
  // fault latches
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shortFault_ff <= 1'b0;
      bootFault_ff <= 1'b0;
    end else if (faultClear) begin
      shortFault_ff <= 1'b0;
      bootFault_ff <= 1'b0;
    end else begin
      shortFault_ff <= shortFault_ff || (|shortHit);
      bootFault_ff <= bootFault_ff || bootstrapTimeoutIn;
    end
  end

  // Bus slave: answers on the second access cycle
  assign apbDone = psel && penable && pready;
  assign apbRead = apbDone && !pwrite;

  always_comb begin
    rdMux = 32'h0;
    rdHit = 1'b1;
    case (paddr)
      ADDR_CTRL: rdMux[CTRL_SW_DISABLE] = swDisable_ff;
      ADDR_DEAD: rdMux[TIME_W-1:0] = deadTime_ff;
      ADDR_BLANK: rdMux[TIME_W-1:0] = blankTime_ff;
      // Informative only: pin state, fault latches, spare pair, transistors on
      ADDR_STATUS: rdMux[9:0] = {pinState_ff, bootFault_ff, shortFault_ff, 2'h0, fetOn};
      ADDR_INT_STAT: rdMux[3:0] = intStat_ff;
      ADDR_INT_MASK: rdMux[3:0] = intMask_ff;
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rdHit;
      prdata <= (psel && penable && !pready && !pwrite) ? rdMux : 32'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      swDisable_ff <= 1'b0;
      deadTime_ff <= DEAD_RESET;
      blankTime_ff <= BLANK_RESET;
      intMask_ff <= INT_MASK_RESET;
    end else if (apbDone && pwrite) begin
      case (paddr)
        ADDR_CTRL: swDisable_ff <= pwdata[CTRL_SW_DISABLE];
        ADDR_DEAD: deadTime_ff <= pwdata[TIME_W-1:0];
        ADDR_BLANK: blankTime_ff <= pwdata[TIME_W-1:0];
        ADDR_INT_MASK: intMask_ff <= pwdata[3:0];
        default: swDisable_ff <= swDisable_ff;
      endcase
    end
  end

  // Sticky events; a new event beats the read-clear in the same cycle
  always_comb begin
    intEvt = 4'h0;
    intEvt[INT_SHORT] = !shortFault_ff && !faultClear && (|shortHit);
    intEvt[INT_BOOT] = !bootFault_ff && !faultClear && bootstrapTimeoutIn;
    intEvt[INT_SLEEP] = (pinState_ff == PIN_LOW) && !resetPinN && (pinCnt_ff >= SLEEP_LAST);
    intEvt[INT_WAKE] = (pinState_ff == PIN_WAKE) && resetPinN && (pinCnt_ff >= PUMP_LAST);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      intStat_ff <= 4'h0;
      irqOut <= 1'b0;
    end else begin
      intStat_ff <= ((apbRead && paddr == ADDR_INT_STAT) ? 4'h0 : intStat_ff) | intEvt;
      irqOut <= |(intStat_ff & intMask_ff);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sleepOut <= 1'b0;
      faultOut <= 1'b0;
    end else begin
      sleepOut <= (pinState_ff == PIN_SLEEP);
      faultOut <= shortFault_ff || bootFault_ff;
    end
  end

  assign gateTopLegA = gateHi_ff[0];
  assign gateBottomLegA = gateLo_ff[0];
  assign gateTopLegB = gateHi_ff[1];
  assign gateBottomLegB = gateLo_ff[1];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_leg_exclusive: assert property (
    !(gateHi_ff[0] && gateLo_ff[0]) && !(gateHi_ff[1] && gateLo_ff[1]))
    else $error("both gates of one leg on");
  a_drive_a_high: assert property (
    highSideChopIn && lowSideChopIn && directionIn |-> tgtHi == 2'h1 && tgtLo == 2'h2)
    else $error("drive A high decode wrong");
  a_drive_b_high: assert property (
    highSideChopIn && lowSideChopIn && !directionIn |-> tgtHi == 2'h2 && tgtLo == 2'h1)
    else $error("drive B high decode wrong");
  a_low_brake: assert property (
    !highSideChopIn && lowSideChopIn && syncRectifyEnable |-> tgtLo == 2'h3 && tgtHi == 2'h0)
    else $error("low-side brake decode wrong");
  a_high_brake: assert property (
    highSideChopIn && !lowSideChopIn && syncRectifyEnable |-> tgtHi == 2'h3 && tgtLo == 2'h0)
    else $error("high-side brake decode wrong");
  a_low_diode_decay: assert property (
    !highSideChopIn && lowSideChopIn && !syncRectifyEnable
    |-> tgtLo == (directionIn ? 2'h2 : 2'h1) && tgtHi == 2'h0)
    else $error("low-side diode decay decode wrong");
  a_high_diode_decay: assert property (
    highSideChopIn && !lowSideChopIn && !syncRectifyEnable
    |-> tgtHi == (directionIn ? 2'h1 : 2'h2) && tgtLo == 2'h0)
    else $error("high-side diode decay decode wrong");
  a_coast_all_off: assert property (
    !highSideChopIn && !lowSideChopIn |=> fetOn == 4'h0)
    else $error("coast did not turn gates off");
  a_dead_gap: assert property (
    $fell(gateHi_ff[0]) && deadTime_ff > 16'h1 |=> !gateLo_ff[0])
    else $error("complement turned on inside dead time");
  a_sleep_entry: assert property (
    pinState_ff == PIN_LOW && !resetPinN && pinCnt_ff >= SLEEP_LAST |=> ##1 sleepOut)
    else $error("sleep not entered after delay");
  a_sleep_clears: assert property (
    pinState_ff == PIN_SLEEP |=> !shortFault_ff && !bootFault_ff)
    else $error("latched fault survived sleep");
  a_wake_gates_off: assert property (
    pinState_ff == PIN_WAKE |=> fetOn == 4'h0)
    else $error("gate on before charge pump settled");
  a_blank_short: assert property (
    $rose(shortFault_ff) |-> $past((fetOn[0] && shortCmpIn[0] && blankCnt_ff[0] == '0)
      || (fetOn[1] && shortCmpIn[1] && blankCnt_ff[1] == '0)
      || (fetOn[2] && shortCmpIn[2] && blankCnt_ff[2] == '0)
      || (fetOn[3] && shortCmpIn[3] && blankCnt_ff[3] == '0)))
    else $error("short latched during blanking");
  a_detect_disabled: assert property (
    (shortDisableIn || swDisable_ff) && !shortFault_ff |=> !shortFault_ff)
    else $error("short detected while disabled");
endmodule : full_bridge_gate_control
`default_nettype wire

/* chop_model.sv */
// Controller model that drives the bridge logic pins
`timescale 1ns/1ns
`default_nettype none
module chop_model (
  input wire logic sys_clk,
  output logic highSideChopIn,
  output logic lowSideChopIn,
  output logic directionIn,
  output logic syncRectifyEnable,
  output logic resetPinN
);
  initial begin
    {highSideChopIn, lowSideChopIn, directionIn, syncRectifyEnable} = 4'h0;
    resetPinN = 1'b1;
  end
  task automatic set_pins(input logic [3:0] v);
    @(posedge sys_clk);
    {highSideChopIn, lowSideChopIn, directionIn, syncRectifyEnable} <= v;
  endtask : set_pins
  task automatic pulse_reset(input int n);
    @(posedge sys_clk);
    resetPinN <= 1'b0;
    repeat (n) @(posedge sys_clk);
    resetPinN <= 1'b1;
  endtask : pulse_reset
endmodule : chop_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the full-bridge gate control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import gate_ctrl_pkg::*;
  localparam int SLP = 50;
  localparam int PMP = 80;
  localparam int DT = 4;
  localparam int BL = 20;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic h, l, d, sr, rstN, shortDisableIn, bootstrapTimeoutIn;
  logic [3:0] shortCmpIn;
  logic gTA, gBA, gTB, gBB, sleepOut, faultOut, irqOut;
  int fails = 0;
  int comparisons = 0;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  full_bridge_gate_control #(.SLEEP_CYC(SLP), .PUMP_CYC(PMP)) i_full_bridge_gate_control (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .highSideChopIn(h),
    .lowSideChopIn(l),
    .directionIn(d),
    .syncRectifyEnable(sr),
    .resetPinN(rstN),
    .shortCmpIn(shortCmpIn),
    .shortDisableIn(shortDisableIn),
    .bootstrapTimeoutIn(bootstrapTimeoutIn),
    .gateTopLegA(gTA),
    .gateBottomLegA(gBA),
    .gateTopLegB(gTB),
    .gateBottomLegB(gBB),
    .sleepOut(sleepOut),
    .faultOut(faultOut),
    .irqOut(irqOut)
  );
  chop_model i_chop_model (
    .sys_clk(sys_clk),
    .highSideChopIn(h),
    .lowSideChopIn(l),
    .directionIn(d),
    .syncRectifyEnable(sr),
    .resetPinN(rstN)
  );
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  task automatic set_monitor(input logic [3:0] cmp, input logic dis);
    @(posedge sys_clk);
    shortCmpIn <= cmp;
    shortDisableIn <= dis;
  endtask : set_monitor
  // Bounded wait: 0 pready, 1 top A, 2 bottom A, 3 fault
  task automatic wait_hi(input int sel, input int bound, output int n);
    logic [3:0] v;
    for (n = 0; n < bound; n++) begin
      @(negedge sys_clk);
      v = {faultOut, gBA, gTA, pready};
      if (v[sel] === 1'b1) return;
    end
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask : wait_hi
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Answer is taken at the very edge that sees pready, then released
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n < 20) begin
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end else begin
      fails++;
      $display("[ERR] %0t bus answer timed out", $time);
      tally_and_finish();
    end
  endtask : apb
  // Expected {top A, bottom A, top B, bottom B} from {high, low, dir, rectify}
  function automatic logic [3:0] decode(input logic [3:0] v);
    case (v[3:2])
      2'b11: return v[1] ? 4'h9 : 4'h6;
      2'b01: return v[0] ? 4'h5 : (v[1] ? 4'h1 : 4'h4);
      2'b10: return v[0] ? 4'ha : (v[1] ? 4'h8 : 4'h2);
      default: return 4'h0;
    endcase
  endfunction : decode
  always @(negedge sys_clk) begin
    if (!sys_rst && ((gTA && gBA) || (gTB && gBB))) begin
      fails++;
      $display("[ERR] %0t leg cross-conduction", $time);
    end
  end
  task automatic test_regs;
    logic [31:0] q;
    logic e;
    apb(1'b0, ADDR_DEAD, 32'h0, q, e);
    check(q, 32'(DEAD_RESET), "dead reset value");
    apb(1'b0, ADDR_BLANK, 32'h0, q, e);
    check(q, 32'(BLANK_RESET), "blank reset value");
    apb(1'b0, ADDR_INT_MASK, 32'h0, q, e);
    check(q, 32'(INT_MASK_RESET), "mask reset value");
    apb(1'b0, 8'h40, 32'h0, q, e);
    check({q[30:0], e}, 32'h1, "unmapped access");
    apb(1'b1, ADDR_DEAD, 32'(DT), q, e);
    apb(1'b1, ADDR_BLANK, 32'(BL), q, e);
    apb(1'b0, ADDR_BLANK, 32'h0, q, e);
    check(q, 32'(BL), "blank readback");
    $display("test_regs done");
  endtask : test_regs
  task automatic test_table;
    for (int i = 0; i < 16; i++) begin
      i_chop_model.set_pins(4'(i));
      repeat (DT + 8) @(negedge sys_clk);
      check({gTA, gBA, gTB, gBB}, decode(4'(i)), "decode");
    end
    $display("test_table done");
  endtask : test_table
  task automatic test_dead;
    int n;
    i_chop_model.set_pins(4'b1110);
    repeat (DT + 8) @(negedge sys_clk);
    i_chop_model.set_pins(4'b1100);
    wait_hi(2, DT + 20, n);
    check(n >= DT + 1 && n <= DT + 3, 1, "dead time");
    $display("test_dead done");
  endtask : test_dead
  task automatic test_short;
    int n;
    logic [31:0] q;
    logic e;
    i_chop_model.set_pins(4'b0000);
    set_monitor(4'h1, 1'b0);
    repeat (4) @(posedge sys_clk);
    i_chop_model.set_pins(4'b1110);
    wait_hi(3, BL + 20, n);
    check(n >= BL, 1, "blanking");
    check({gTA, gBA, gTB, gBB, irqOut}, 0, "fault gates off, irq masked");
    apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    check(q, 32'h40, "status shows short latch");
    apb(1'b1, ADDR_INT_MASK, 32'h1, q, e);
    repeat (3) @(negedge sys_clk);
    check(irqOut, 1, "irq raised");
    apb(1'b0, ADDR_INT_STAT, 32'h0, q, e);
    check(q[0], 1, "short event");
    repeat (3) @(negedge sys_clk);
    check(irqOut, 0, "irq cleared by read");
    set_monitor(4'h0, 1'b0);
    i_chop_model.pulse_reset(5);
    repeat (3) @(negedge sys_clk);
    check({faultOut, sleepOut}, 0, "short pulse clears");
    wait_hi(1, DT + 10, n);
    set_monitor(4'hf, 1'b1);
    repeat (BL + 20) @(negedge sys_clk);
    check(faultOut, 0, "detection off");
    apb(1'b1, ADDR_CTRL, 32'h1, q, e);
    set_monitor(4'hf, 1'b0);
    repeat (BL + 20) @(negedge sys_clk);
    check(faultOut, 0, "software detection off");
    set_monitor(4'h0, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0, q, e);
    check(q, 32'h1, "control readback");
    apb(1'b1, ADDR_CTRL, 32'h0, q, e);
    $display("test_short done");
  endtask : test_short
  task automatic test_sleep;
    int n;
    logic [31:0] q;
    logic e;
    apb(1'b1, ADDR_INT_MASK, 32'hf, q, e);
    @(posedge sys_clk);
    bootstrapTimeoutIn <= 1'b1;
    @(posedge sys_clk);
    bootstrapTimeoutIn <= 1'b0;
    wait_hi(3, 10, n);
    fork
      i_chop_model.pulse_reset(SLP + 10);
      begin
        repeat (SLP + 6) @(negedge sys_clk);
        check({sleepOut, faultOut, gTA, gBA, gTB, gBB}, 6'h20, "asleep");
      end
    join
    wait_hi(1, PMP + DT + 20, n);
    check(n >= PMP - 2, 1, "pump settle");
    apb(1'b0, ADDR_INT_STAT, 32'h0, q, e);
    check(q[3:1], 3'h7, "sleep and wake events");
    $display("test_sleep done");
  endtask : test_sleep
  initial begin
    int n;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {shortCmpIn, shortDisableIn, bootstrapTimeoutIn} = '0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    i_chop_model.set_pins(4'b1110);
    wait_hi(1, PMP + 700, n);
    test_regs();
    test_table();
    test_dead();
    test_short();
    test_sleep();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
